//--- design/nvm_map.vh
/*
 Constants for the nonvolatile access controller: register selects,
 control bit positions, mask values, unlock keys and timing defaults.
 Assumes inclusion by bare name from the design files of this block.
*/
`ifndef NVM_MAP_VH
`define NVM_MAP_VH

// =====================================================================
// Register selects on the special function register port
`define NVM_SEL_DATA_LOW   3'h0
`define NVM_SEL_ADDR_LOW   3'h1
`define NVM_SEL_DATA_HIGH  3'h2
`define NVM_SEL_ADDR_HIGH  3'h3
`define NVM_SEL_CONTROL    3'h4
`define NVM_SEL_UNLOCK     3'h5

// =====================================================================
// Control register bit positions
`define NVM_CTL_RD         0
`define NVM_CTL_WR         1
`define NVM_CTL_PERMIT     2
`define NVM_CTL_ABORT      3
`define NVM_CTL_SPACE      7

// =====================================================================
// Implemented-bit masks and reset values
`define NVM_ADDR_HIGH_MASK 8'h1F
`define NVM_DATA_HIGH_MASK 8'h3F
`define NVM_REG_RESET      8'h00
`define NVM_ZERO_BYTE      8'h00
`define NVM_ERASED_BYTE    8'hFF

// =====================================================================
// Unlock key sequence
`define NVM_KEY_FIRST      8'h55
`define NVM_KEY_SECOND     8'hAA

// =====================================================================
// Sizes and timing
`define NVM_DATA_ADDR_W    8
`define NVM_PROG_ADDR_W    13
`define NVM_PROG_DATA_W    14
`define NVM_WRITE_CYCLES   250000
`define NVM_TIMER_W        20

// =====================================================================
// Self-write protection upper limits (word address, exclusive)
`define NVM_WRT_OFF        2'h3
`define NVM_WRT_LIM_LOW    13'h0100
`define NVM_WRT_LIM_HALF   13'h0800
`define NVM_WRT_LIM_FULL   13'h1FFF

`endif

//--- design/nvm_eeprom_array.v
/*
 Data EEPROM byte array with its own write timer: erase on start,
 program on timer expiry, abandon on abort.
 Assumes one clock; abort is a same-clock level from the reset logic.
*/
`timescale 1ns/100ps
`include "nvm_map.vh"

module nvm_eeprom_array #(
	parameter ADDR_W       = `NVM_DATA_ADDR_W,
	parameter DEPTH        = 256,
	parameter TIMER_W      = `NVM_TIMER_W,
	parameter WRITE_CYCLES = `NVM_WRITE_CYCLES
) (
	// Clock and reset
	input  wire              clk,
	input  wire              rst_b,
	input  wire              abort,
	// Read side
	input  wire [ADDR_W-1:0] rd_addr,
	output wire [7:0]        rd_data,
	// Write side
	input  wire              wr_start,
	input  wire [ADDR_W-1:0] wr_addr,
	input  wire [7:0]        wr_data,
	output reg               busy,
	output reg               done
);

	// =================================================================
	// Storage
	reg [7:0]         mem [0:DEPTH-1];   // Byte cells
	reg [ADDR_W-1:0]  hold_addr;         // Address held for the cycle
	reg [7:0]         hold_data;         // Data held for the cycle
	reg [TIMER_W-1:0] timer;             // Cycles left in the write

	// Reads see the cells directly, so a read lands in one cycle
	assign rd_data = mem[rd_addr];

	// =================================================================
	// Cell updates: erase at start, program at end
	always @(posedge clk) begin
		if (wr_start && !busy) begin
			mem[wr_addr] <= `NVM_ERASED_BYTE;
		end else if (busy && !abort && timer == {TIMER_W{1'b0}}) begin
			mem[hold_addr] <= hold_data;
		end
	end

	// =================================================================
	// Write timer; software never sets the duration
	always @(posedge clk) begin
		if (!rst_b) begin
			busy      <= 1'b0;
			done      <= 1'b0;
			timer     <= {TIMER_W{1'b0}};
			hold_addr <= {ADDR_W{1'b0}};
			hold_data <= `NVM_ZERO_BYTE;
		end else begin
			done <= 1'b0;
			if (busy) begin
				if (abort) begin
					// Cut short: the cell stays erased
					busy <= 1'b0;
				end else if (timer == {TIMER_W{1'b0}}) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					timer <= timer - {{(TIMER_W-1){1'b0}}, 1'b1};
				end
			end else if (wr_start) begin
				busy      <= 1'b1;
				hold_addr <= wr_addr;
				hold_data <= wr_data;
				timer     <= WRITE_CYCLES[TIMER_W-1:0] - {{(TIMER_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule

//--- design/nvm_ctrl.v
/*
 Nonvolatile memory access controller: indirect address, data and
 control registers, unlock sequence, data EEPROM byte read and timed
 write, program flash word read, abort and completion flags.
 Assumes the CPU drives the register port on this clock, one access
 per cycle, and that program flash answers prog_rdata combinationally
 while prog_rd is high. Abort resets are same-clock levels.
*/
// Contract
// - Data array holds 256 bytes, 8-bit address.
// - Data pair gives 14-bit word; address pair.
// - Program address reaches up to 8K words.
// - Byte write erases then programs the cell.
// - Internal timer sets write length; flags report.
// - Self-write protection blocks program writes only.
// - Code protection denies programmer, not CPU.
// - Space select bit 7, cleared by reset.
// - Read/write strobes set-only, self-clearing.
// - Write strobe ignored unless permit already set.
// - Permit clear at power-up and abort resets, else software-only clear.
// - Clearing permit never disturbs running write.
// - Abort flag on reset-cut write, zero after completion.
// - Completion clears strobe, sets sticky done flag.
// - Unlock port stores nothing, reads zero.
// - Write needs 55h, AAh, then write strobe.
// - Data read lands in low data next cycle.
// - Low data holds until read or software write.
// - Unimplemented register bits read zero.
// - Program read takes second cycle; CPU ignores it.
// - Write strobe in program space clears, no-op.
`timescale 1ns/100ps
`include "nvm_map.vh"

module nvm_ctrl #(
	parameter DATA_DEPTH   = 256,
	parameter WRITE_CYCLES = `NVM_WRITE_CYCLES
) (
	// Clock and power-on reset
	input  wire                         clk,
	input  wire                         rst_b,
	// Resets that cut a write short
	input  wire                         ext_reset,
	input  wire                         watchdog_timeout,
	input  wire                         brownout_reset,
	// Register port
	input  wire [2:0]                   reg_sel,
	input  wire                         reg_wr,
	input  wire [7:0]                   reg_wdata,
	input  wire                         reg_rd,
	output reg  [7:0]                   reg_rdata,
	// Completion flag
	input  wire                         done_flag_clear,
	output reg                          write_done_flag,
	output reg                          write_busy,
	// Program flash read port
	output reg  [`NVM_PROG_ADDR_W-1:0]  prog_addr,
	output reg                          prog_rd,
	input  wire [`NVM_PROG_DATA_W-1:0]  prog_rdata,
	output reg                          cpu_ignore,
	// Protection
	input  wire [1:0]                   self_write_protect,
	input  wire                         code_protect,
	input  wire                         programmer_req,
	output reg                          programmer_grant,
	output reg                          prog_write_blocked
);

	// =================================================================
	// Program read sequencer states
	localparam ST_IDLE  = 3'b001;  // Nothing pending
	localparam ST_WAIT  = 3'b010;  // First cycle after strobe runs
	localparam ST_FETCH = 3'b100;  // Flash read; CPU ignores cycle

	// Unlock progress
	localparam KEY_NONE  = 2'h0;   // No key seen
	localparam KEY_FIRST = 2'h1;   // First key seen
	localparam KEY_ARMED = 2'h2;   // Both keys seen

	// =================================================================
	// Registers
	reg  [7:0]  data_low;          // Low data byte
	reg  [7:0]  data_high;         // High data byte, six bits live
	reg  [7:0]  addr_low;          // Low address byte
	reg  [7:0]  addr_high;         // High address byte, five bits live
	reg         space_select;      // 1 program, 0 data
	reg         write_permit;      // Write gate
	reg         write_abort_flag;  // Write cut short by reset
	reg         rd_strobe;         // Read in progress
	reg         wr_strobe;         // Write in progress
	reg  [1:0]  key_stage;         // Unlock progress
	reg  [2:0]  state;             // Program read sequencer
	reg  [2:0]  next_state;        // Sequencer next value

	// =================================================================
	// Decode
	wire        abort_rst   = ext_reset | watchdog_timeout | brownout_reset;
	wire        sys_rst     = !rst_b || abort_rst;
	wire        ctl_wr      = reg_wr && reg_sel == `NVM_SEL_CONTROL;
	wire        key_wr      = reg_wr && reg_sel == `NVM_SEL_UNLOCK;
	wire        new_space   = reg_wdata[`NVM_CTL_SPACE];
	wire        rd_req      = ctl_wr && reg_wdata[`NVM_CTL_RD] && !rd_strobe && state == ST_IDLE;
	wire [7:0]  array_rdata;       // Byte at the low address
	wire        array_busy;        // Timed write running
	wire        array_done;        // Write finished, one cycle
	// Permit must already be set; the same write cannot grant it
	wire        wr_req      = ctl_wr && reg_wdata[`NVM_CTL_WR] && !wr_strobe && write_permit &&
	                          key_stage == KEY_ARMED;
	// An abort reset in the same cycle must not start the array
	wire        data_wr_go  = wr_req && !new_space && !array_busy && !abort_rst;
	wire [`NVM_PROG_ADDR_W-1:0] word_addr;

	assign word_addr = {addr_high[4:0], addr_low};

	// Protected upper bound for a self-write setting
	function [`NVM_PROG_ADDR_W-1:0] wrt_limit;
		input [1:0] wrt;
		begin
			case (wrt)
				2'h2:    wrt_limit = `NVM_WRT_LIM_LOW;
				2'h1:    wrt_limit = `NVM_WRT_LIM_HALF;
				2'h0:    wrt_limit = `NVM_WRT_LIM_FULL;
				default: wrt_limit = {`NVM_PROG_ADDR_W{1'b0}};
			endcase
		end
	endfunction

	// =================================================================
	// Data EEPROM with its write timer
	nvm_eeprom_array #(
		.ADDR_W       (`NVM_DATA_ADDR_W),
		.DEPTH        (DATA_DEPTH),
		.TIMER_W      (`NVM_TIMER_W),
		.WRITE_CYCLES (WRITE_CYCLES)
	) u_array (
		.clk      (clk),
		.rst_b    (rst_b),
		.abort    (abort_rst),
		.rd_addr  (addr_low),
		.rd_data  (array_rdata),
		.wr_start (data_wr_go),
		.wr_addr  (addr_low),
		.wr_data  (data_low),
		.busy     (array_busy),
		.done     (array_done)
	);

	// =================================================================
	// Program read sequencer, next state
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (rd_req && new_space) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT:  next_state = ST_FETCH;
			ST_FETCH: next_state = ST_IDLE;
			default:  next_state = ST_IDLE;
		endcase
	end

	// =================================================================
	// Sequencer state and flash port
	always @(posedge clk) begin
		if (sys_rst) begin
			state      <= ST_IDLE;
			prog_rd    <= 1'b0;
			cpu_ignore <= 1'b0;
			prog_addr  <= {`NVM_PROG_ADDR_W{1'b0}};
		end else begin
			state      <= next_state;
			// Flash is busy in the second cycle, so that slot is lost
			prog_rd    <= state == ST_WAIT;
			cpu_ignore <= state == ST_WAIT;
			if (rd_req && new_space) begin
				prog_addr <= word_addr;
			end
		end
	end

	// =================================================================
	// Unlock key tracking; any other write breaks the sequence
	always @(posedge clk) begin
		if (sys_rst) begin
			key_stage <= KEY_NONE;
		end else if (key_wr) begin
			if (reg_wdata == `NVM_KEY_FIRST) begin
				key_stage <= KEY_FIRST;
			end else if (reg_wdata == `NVM_KEY_SECOND && key_stage == KEY_FIRST) begin
				key_stage <= KEY_ARMED;
			end else begin
				key_stage <= KEY_NONE;
			end
		end else if (reg_wr) begin
			key_stage <= KEY_NONE;
		end
	end

	// =================================================================
	// Address and data registers
	always @(posedge clk) begin
		if (sys_rst) begin
			addr_low  <= `NVM_REG_RESET;
			addr_high <= `NVM_REG_RESET;
			data_low  <= `NVM_REG_RESET;
			data_high <= `NVM_REG_RESET;
		end else begin
			if (reg_wr && reg_sel == `NVM_SEL_ADDR_LOW) begin
				addr_low <= reg_wdata;
			end
			if (reg_wr && reg_sel == `NVM_SEL_ADDR_HIGH) begin
				addr_high <= reg_wdata & `NVM_ADDR_HIGH_MASK;
			end
			if (state == ST_FETCH) begin
				// Program word split over the pair
				data_low  <= prog_rdata[7:0];
				data_high <= {2'b00, prog_rdata[`NVM_PROG_DATA_W-1:8]};
			end else if (rd_req && !new_space) begin
				data_low <= array_rdata;
			end else begin
				if (reg_wr && reg_sel == `NVM_SEL_DATA_LOW) begin
					data_low <= reg_wdata;
				end
				if (reg_wr && reg_sel == `NVM_SEL_DATA_HIGH) begin
					data_high <= reg_wdata & `NVM_DATA_HIGH_MASK;
				end
			end
		end
	end

	// =================================================================
	// Control bits and strobes
	always @(posedge clk) begin
		if (sys_rst) begin
			space_select <= 1'b0;
			write_permit <= 1'b0;
			rd_strobe    <= 1'b0;
			wr_strobe    <= 1'b0;
		end else begin
			if (ctl_wr) begin
				space_select <= new_space;
				// Only software and the resets move the permit bit
				write_permit <= reg_wdata[`NVM_CTL_PERMIT];
			end
			// Strobes: software sets, hardware clears
			if (rd_req && new_space) begin
				rd_strobe <= 1'b1;
			end else if (state == ST_FETCH) begin
				rd_strobe <= 1'b0;
			end
			// Data read finishes at once; program space write is a no-op
			if (data_wr_go) begin
				wr_strobe <= 1'b1;
			end else if (array_done) begin
				wr_strobe <= 1'b0;
			end
		end
	end

	// =================================================================
	// Abort flag survives the abort resets; power-on or write completion clears it, and a control write loads it from bit 3
	always @(posedge clk) begin
		if (!rst_b) begin
			write_abort_flag <= 1'b0;
		end else if (abort_rst && array_busy) begin
			write_abort_flag <= 1'b1;
		end else if (array_done) begin
			write_abort_flag <= 1'b0;
		end else if (ctl_wr && !abort_rst) begin
			write_abort_flag <= reg_wdata[`NVM_CTL_ABORT];
		end
	end

	// =================================================================
	// Completion flag: set beats a same-cycle clear
	always @(posedge clk) begin
		if (sys_rst) begin
			write_done_flag <= 1'b0;
			write_busy      <= 1'b0;
		end else begin
			write_busy <= array_busy || data_wr_go;
			if (array_done) begin
				write_done_flag <= 1'b1;
			end else if (done_flag_clear) begin
				write_done_flag <= 1'b0;
			end
		end
	end

	// =================================================================
	// Protection status; CPU reads never depend on either setting
	always @(posedge clk) begin
		if (sys_rst) begin
			programmer_grant   <= 1'b0;
			prog_write_blocked <= 1'b0;
		end else begin
			programmer_grant   <= programmer_req && !code_protect;
			prog_write_blocked <= self_write_protect != `NVM_WRT_OFF &&
			                      word_addr < wrt_limit(self_write_protect);
		end
	end

	// =================================================================
	// Register read mux, answered one cycle after the request
	always @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= `NVM_REG_RESET;
		end else if (reg_rd) begin
			case (reg_sel)
				`NVM_SEL_DATA_LOW:  reg_rdata <= data_low;
				`NVM_SEL_ADDR_LOW:  reg_rdata <= addr_low;
				`NVM_SEL_DATA_HIGH: reg_rdata <= data_high;
				`NVM_SEL_ADDR_HIGH: reg_rdata <= addr_high;
				`NVM_SEL_CONTROL:   reg_rdata <= {space_select, 3'b000, write_abort_flag,
				                                  write_permit, wr_strobe, rd_strobe};
				`NVM_SEL_UNLOCK:    reg_rdata <= `NVM_ZERO_BYTE;
				default:            reg_rdata <= `NVM_ZERO_BYTE;
			endcase
		end
	end

endmodule

//--- test/nvm_ctrl_chk.sv
/*
 Port-level checker for nvm_ctrl: strobes, key port, flags, write timing.
 Assumes a bind onto nvm_ctrl and a single clock domain.
*/
`timescale 1ns/100ps
`include "nvm_map.vh"

module nvm_ctrl_chk #(
	parameter WRITE_CYCLES = 20
) (
	// Clock and resets
	input wire                         clk,
	input wire                         rst_b,
	input wire                         ext_reset,
	input wire                         watchdog_timeout,
	input wire                         brownout_reset,
	// Register port
	input wire [2:0]                   reg_sel,
	input wire                         reg_wr,
	input wire [7:0]                   reg_wdata,
	input wire                         reg_rd,
	input wire [7:0]                   reg_rdata,
	// Flags
	input wire                         done_flag_clear,
	input wire                         write_done_flag,
	input wire                         write_busy,
	// Flash and protection
	input wire [`NVM_PROG_ADDR_W-1:0]  prog_addr,
	input wire                         prog_rd,
	input wire [`NVM_PROG_DATA_W-1:0]  prog_rdata,
	input wire                         cpu_ignore,
	input wire [1:0]                   self_write_protect,
	input wire                         code_protect,
	input wire                         programmer_req,
	input wire                         programmer_grant,
	input wire                         prog_write_blocked
);
	// ==========================================================
	// Helper state
	wire      abort_any = ext_reset | watchdog_timeout | brownout_reset; // Resets that cut writes
	reg [1:0] key_st;   // Unlock progress seen on the port
	reg       go_seen;  // Armed control write carrying the strobe
	integer   busy_cnt; // Length of the running busy stretch

	// Follow the keys; any other register write breaks the chain
	always @(posedge clk) begin
		if (!rst_b || abort_any) begin
			key_st <= 2'h0;
			go_seen <= 1'b0;
		end else begin
			go_seen <= reg_wr && reg_sel == `NVM_SEL_CONTROL && key_st == 2'h2 && reg_wdata[1];
			if (reg_wr && reg_sel == `NVM_SEL_UNLOCK && reg_wdata == `NVM_KEY_FIRST)
				key_st <= 2'h1;
			else if (reg_wr && reg_sel == `NVM_SEL_UNLOCK && reg_wdata == `NVM_KEY_SECOND && key_st == 2'h1)
				key_st <= 2'h2;
			else if (reg_wr)
				key_st <= 2'h0;
		end
	end

	// Busy run length, cleared whenever idle
	always @(posedge clk) begin
		if (!rst_b || !write_busy)
			busy_cnt <= 0;
		else
			busy_cnt <= busy_cnt + 1;
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	prog_pulse_a: assert property (prog_rd |-> cpu_ignore ##1 !prog_rd)
		else $error("flash read pulse malformed");
	slot_pair_a: assert property (cpu_ignore |-> prog_rd)
		else $error("lost slot without flash read");
	read_launch_a: assert property (
		reg_wr && reg_sel == `NVM_SEL_CONTROL && reg_wdata[7] && reg_wdata[0] && !prog_rd && !abort_any
		|-> ##[1:2] prog_rd) else $error("flash read not launched");
	start_cause_a: assert property ($rose(write_busy) |-> go_seen || $past(go_seen))
		else $error("write started without unlock");
	busy_len_a: assert property (
		$fell(write_busy) && !$past(abort_any) |-> busy_cnt >= WRITE_CYCLES - 1 && busy_cnt <= WRITE_CYCLES + 3)
		else $error("write length off");
	done_after_a: assert property ($rose(write_done_flag) |-> $past(write_busy) ##[0:2] !write_busy)
		else $error("done flag without finished write");
	done_hold_a: assert property (
		write_done_flag && !done_flag_clear && !abort_any |=> write_done_flag)
		else $error("done flag dropped");
	done_clear_a: assert property (done_flag_clear && !write_busy && !abort_any |=> !write_done_flag)
		else $error("done flag not cleared");
	key_zero_a: assert property (reg_rd && reg_sel == `NVM_SEL_UNLOCK |=> reg_rdata == 8'h00)
		else $error("key port read not zero");
	addr_high_a: assert property (reg_rd && reg_sel == `NVM_SEL_ADDR_HIGH |=> reg_rdata[7:5] == 3'h0)
		else $error("address high spare bits set");
	control_gap_a: assert property (reg_rd && reg_sel == `NVM_SEL_CONTROL |=> reg_rdata[6:4] == 3'h0)
		else $error("control spare bits set");
	grant_follow_a: assert property (
		$past(rst_b) && !$past(abort_any) |-> programmer_grant == ($past(programmer_req) && !$past(code_protect)))
		else $error("programmer grant wrong");
endmodule

bind nvm_ctrl nvm_ctrl_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
	.clk(clk), .rst_b(rst_b), .ext_reset(ext_reset), .watchdog_timeout(watchdog_timeout),
	.brownout_reset(brownout_reset), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .done_flag_clear(done_flag_clear),
	.write_done_flag(write_done_flag), .write_busy(write_busy), .prog_addr(prog_addr), .prog_rd(prog_rd),
	.prog_rdata(prog_rdata), .cpu_ignore(cpu_ignore), .self_write_protect(self_write_protect),
	.code_protect(code_protect), .programmer_req(programmer_req), .programmer_grant(programmer_grant),
	.prog_write_blocked(prog_write_blocked)
);

//--- test/test_nonvolatile_mem_access_ctrl.sv
/*
 Self-checking bench for nvm_ctrl: registers, unlock, writes, aborts, flash read.
 Assumes a short write timer; the bench stands in for CPU and flash.
*/
`timescale 1ns/100ps
`include "nvm_map.vh"

module test_nonvolatile_mem_access_ctrl;
	localparam [13:0] PWORD = {1'b1, 13'h1234 ^ 13'h0A5A}; // Flash word at 0x1234
	// Stimulus
	reg        clk = 1'b0;
	reg        rst_b = 1'b0;
	reg        ext_reset = 1'b0;
	reg        watchdog_timeout = 1'b0;
	reg        brownout_reset = 1'b0;
	reg [2:0]  reg_sel = 3'h0;
	reg        reg_wr = 1'b0;
	reg [7:0]  reg_wdata = 8'h00;
	reg        reg_rd = 1'b0;
	reg        done_flag_clear = 1'b0;
	reg [1:0]  self_write_protect = 2'h3;
	reg        code_protect = 1'b0;
	reg        programmer_req = 1'b0;
	// Observed
	wire [7:0]  reg_rdata;
	wire        write_done_flag, write_busy, prog_rd, cpu_ignore, programmer_grant, prog_write_blocked;
	wire [12:0] prog_addr;
	wire [13:0] flash_word = {1'b1, prog_addr ^ 13'h0A5A}; // Flash content model
	// Inverted word outside the read pulse, so a late sample shows
	wire [13:0] prog_rdata = prog_rd ? flash_word : ~flash_word;
	integer     n_errors = 0;
	integer     checked = 0;
	integer     i;

	always #10 clk = ~clk;

	nvm_ctrl #(.WRITE_CYCLES(20)) u_dut (
		.clk(clk), .rst_b(rst_b), .ext_reset(ext_reset), .watchdog_timeout(watchdog_timeout),
		.brownout_reset(brownout_reset), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .done_flag_clear(done_flag_clear),
		.write_done_flag(write_done_flag), .write_busy(write_busy), .prog_addr(prog_addr),
		.prog_rd(prog_rd), .prog_rdata(prog_rdata), .cpu_ignore(cpu_ignore),
		.self_write_protect(self_write_protect), .code_protect(code_protect),
		.programmer_req(programmer_req), .programmer_grant(programmer_grant),
		.prog_write_blocked(prog_write_blocked));

	// ==========================================================
	// Common tasks
	task tally_and_finish;
		begin
			if (n_errors == 0 && checked > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task check(input [15:0] exp, input [15:0] got);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
			end
		end
	endtask
	// Limit ran out: count it and stop
	task give_up;
		begin
			n_errors = n_errors + 1;
			tally_and_finish;
		end
	endtask
	// One register write; idle cycle follows so strobes never collide
	task wr(input [2:0] s, input [7:0] d);
		begin
			@(posedge clk) #2 reg_sel = s;
			reg_wdata = d;
			reg_wr = 1'b1;
			@(posedge clk) #2 reg_wr = 1'b0;
		end
	endtask
	// Register read; the answer is registered at the taking edge
	task rd_chk(input [2:0] s, input [7:0] e);
		begin
			@(posedge clk) #2 reg_sel = s;
			reg_rd = 1'b1;
			@(posedge clk) #2 reg_rd = 1'b0;
			check(e, reg_rdata);
		end
	endtask

	// ==========================================================
	// Scenarios
	task t_regs;
		begin
			for (i = 0; i < 6; i = i + 1)
				rd_chk(i[2:0], 8'h00);
			wr(`NVM_SEL_ADDR_HIGH, 8'hFF);
			rd_chk(`NVM_SEL_ADDR_HIGH, 8'h1F);
			wr(`NVM_SEL_DATA_HIGH, 8'hFF);
			rd_chk(`NVM_SEL_DATA_HIGH, 8'h3F);
			wr(`NVM_SEL_CONTROL, 8'h7C);
			rd_chk(`NVM_SEL_CONTROL, 8'h0C);
			wr(`NVM_SEL_UNLOCK, 8'hFF);
			rd_chk(`NVM_SEL_UNLOCK, 8'h00);
			wr(`NVM_SEL_DATA_LOW, 8'h3C);
			rd_chk(`NVM_SEL_DATA_LOW, 8'h3C);
		end
	endtask
	// Start attempt that must be refused; permit must survive
	task t_try(input [7:0] pre, input [7:0] k1, input [7:0] k2, input brk);
		begin
			wr(`NVM_SEL_CONTROL, pre);
			wr(`NVM_SEL_UNLOCK, k1);
			rd_chk(`NVM_SEL_UNLOCK, 8'h00);
			if (brk)
				wr(`NVM_SEL_ADDR_LOW, 8'h10);
			wr(`NVM_SEL_UNLOCK, k2);
			wr(`NVM_SEL_CONTROL, pre | 8'h06);
			rd_chk(`NVM_SEL_CONTROL, pre | 8'h04);
			check(1'b0, write_busy);
		end
	endtask
	// Byte write; src picks an abort reset, zero lets it finish
	task t_write(input [7:0] a, input [7:0] d, input [1:0] src);
		reg [7:0] ab; // Abort bit preset by software; clear on abort runs so only hardware sets it
		begin
			ab = (src != 2'h0) ? 8'h00 : 8'h08;
			wr(`NVM_SEL_ADDR_LOW, a);
			wr(`NVM_SEL_DATA_LOW, d);
			wr(`NVM_SEL_CONTROL, 8'h04 | ab);
			wr(`NVM_SEL_UNLOCK, `NVM_KEY_FIRST);
			wr(`NVM_SEL_UNLOCK, `NVM_KEY_SECOND);
			wr(`NVM_SEL_CONTROL, 8'h06 | ab);
			rd_chk(`NVM_SEL_CONTROL, 8'h06 | ab);
			check(1'b1, write_busy);
			wr(`NVM_SEL_CONTROL, ab);
			rd_chk(`NVM_SEL_CONTROL, 8'h02 | ab);
			if (src != 2'h0) begin
				@(posedge clk) #2 ext_reset = (src == 2'h1);
				watchdog_timeout = (src == 2'h2);
				brownout_reset = (src == 2'h3);
				@(posedge clk) #2 {ext_reset, watchdog_timeout, brownout_reset} = 3'h0;
				rd_chk(`NVM_SEL_CONTROL, 8'h08);
				check(1'b0, write_done_flag);
				check(1'b0, write_busy);
			end else begin
				for (i = 0; i < 100 && write_done_flag !== 1'b1; i = i + 1)
					@(posedge clk) #2;
				if (i == 100)
					give_up;
				rd_chk(`NVM_SEL_CONTROL, 8'h00);
				check(1'b1, write_done_flag);
				check(1'b0, write_busy);
				@(posedge clk) #2 done_flag_clear = 1'b1;
				@(posedge clk) #2 done_flag_clear = 1'b0;
				check(1'b0, write_done_flag);
			end
			// Read the cell back: erased if cut short
			wr(`NVM_SEL_ADDR_LOW, a);
			wr(`NVM_SEL_CONTROL, 8'h01);
			rd_chk(`NVM_SEL_CONTROL, 8'h00);
			rd_chk(`NVM_SEL_DATA_LOW, (src != 2'h0) ? 8'hFF : d);
		end
	endtask
	task t_prog;
		begin
			wr(`NVM_SEL_ADDR_HIGH, 8'h12);
			wr(`NVM_SEL_ADDR_LOW, 8'h34);
			wr(`NVM_SEL_CONTROL, 8'h81);
			for (i = 0; i < 4 && prog_rd !== 1'b1; i = i + 1)
				@(posedge clk) #2;
			if (i == 4)
				give_up;
			check(1'b1, cpu_ignore);
			check(13'h1234, prog_addr);
			rd_chk(`NVM_SEL_DATA_LOW, PWORD[7:0]);
			rd_chk(`NVM_SEL_DATA_HIGH, {2'b00, PWORD[13:8]});
			rd_chk(`NVM_SEL_CONTROL, 8'h80);
		end
	endtask
	task t_prot(input [1:0] p, input [12:0] a, input exp_b);
		begin
			self_write_protect = p;
			wr(`NVM_SEL_ADDR_HIGH, {3'b000, a[12:8]});
			wr(`NVM_SEL_ADDR_LOW, a[7:0]);
			@(posedge clk) #2 check(exp_b, prog_write_blocked);
		end
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		#2 rst_b = 1'b1;
		t_regs;
		t_try(8'h00, `NVM_KEY_FIRST, `NVM_KEY_SECOND, 1'b0);
		t_try(8'h04, `NVM_KEY_FIRST, `NVM_KEY_SECOND, 1'b1);
		t_try(8'h04, `NVM_KEY_SECOND, `NVM_KEY_FIRST, 1'b0);
		t_try(8'h84, `NVM_KEY_FIRST, `NVM_KEY_SECOND, 1'b0);
		t_write(8'hFF, 8'hA5, 2'h1);
		t_write(8'hFF, 8'hA5, 2'h2);
		t_write(8'hFF, 8'hA5, 2'h3);
		t_write(8'h00, 8'h5A, 2'h0);
		t_write(8'hFF, 8'hC3, 2'h0);
		t_prog;
		t_prot(2'h3, 13'h0050, 1'b0);
		t_prot(2'h2, 13'h0050, 1'b1);
		t_prot(2'h2, 13'h0200, 1'b0);
		t_prot(2'h1, 13'h07FF, 1'b1);
		t_prot(2'h0, 13'h1000, 1'b1);
		code_protect = 1'b1;
		programmer_req = 1'b1;
		@(posedge clk) #2 check(1'b0, programmer_grant);
		code_protect = 1'b0;
		@(posedge clk) #2 check(1'b1, programmer_grant);
		tally_and_finish;
	end
	// Hang guard
	initial begin
		#1000000;
		give_up;
	end
endmodule
